// ===== rtl/ssienc_pkg.sv
package ssienc_pkg;

  // Sampling clock
  localparam int CLK_MHZ        = 100;

  // Monoflop time, nominal and tolerance in microseconds
  localparam int MONO_US        = 20;
  localparam int MONO_TOL_US    = 10;
  localparam int MONO_CYC       = MONO_US * CLK_MHZ;
  localparam int MONO_W         = 12;
  localparam logic [MONO_W-1:0] MONO_LOAD = MONO_W'(MONO_CYC - 1);
  localparam logic [MONO_W-1:0] MONO_ZERO = 12'h000;

  // Position layout
  localparam int MT_BITS        = 14;
  localparam int ST_BITS        = 16;
  localparam int POS_BITS       = MT_BITS + ST_BITS;

  // Standard frame: multiturn field, single-turn field, status bit
  localparam int FRM_MT         = 12;
  localparam int FRM_ST         = 12;
  localparam int FRM_ST_LSB     = ST_BITS - FRM_ST;
  localparam int FRM_MT_LSB     = ST_BITS;
  localparam int FIELD_BITS     = FRM_MT + FRM_ST;
  localparam int FRAME_BITS     = FIELD_BITS + 1;

  // Bit counter
  localparam int CNT_W          = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
  localparam logic [CNT_W-1:0] FRAME_CNT = 5'h19;
  localparam logic [CNT_W-1:0] RING_CNT  = 5'h0D;

  // Synchroniser lanes
  localparam int SYNC_W         = 2;
  localparam int SYNC_LINK      = 0;
  localparam int SYNC_DIR       = 1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 2'h3;

  // Line levels
  localparam logic LINE_IDLE    = 1'b1;
  localparam logic LINE_LOW     = 1'b0;

  typedef enum {
    SSIENC_IDLE,
    SSIENC_SHIFT,
    SSIENC_TAIL
  } ssienc_state_t;

endpackage

// ===== rtl/ssienc_ctl_if.sv
`timescale 1ns/100ps
interface ssienc_ctl_if;
  logic link_clk_s;
  logic dir_sel_n_s;
  logic mono_start;
  logic mono_busy;

  modport sync (
    output link_clk_s,
    output dir_sel_n_s
  );
  modport mono (
    input  mono_start,
    output mono_busy
  );
  modport core (
    input  link_clk_s,
    input  dir_sel_n_s,
    output mono_start,
    input  mono_busy
  );
endinterface

// ===== rtl/ssienc_sync.sv
`timescale 1ns/100ps
module ssienc_sync
  import ssienc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic link_clk_i,
  input  wire logic dir_sel_n_i,
  ssienc_ctl_if.sync ctl
);

  logic [SYNC_W-1:0] pin_in;
  logic [SYNC_W-1:0] st1_reg;
  logic [SYNC_W-1:0] st2_reg;

  assign pin_in[SYNC_LINK] = link_clk_i;
  assign pin_in[SYNC_DIR]  = dir_sel_n_i;

  // Two-stage synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_lane
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          st1_reg[g] <= SYNC_RST[g];
          st2_reg[g] <= SYNC_RST[g];
        end else begin
          st1_reg[g] <= pin_in[g];
          st2_reg[g] <= st1_reg[g];
        end
      end
    end
  endgenerate

  assign ctl.link_clk_s  = st2_reg[SYNC_LINK];
  assign ctl.dir_sel_n_s = st2_reg[SYNC_DIR];

endmodule

// ===== rtl/ssienc_mono.sv
`timescale 1ns/100ps
module ssienc_mono
  import ssienc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  ssienc_ctl_if.mono ctl
);

  logic [MONO_W-1:0] cnt_reg;
  logic [MONO_W-1:0] cnt_next;

  // Retriggerable timer
  always_comb begin
    cnt_next = cnt_reg;
    if (ctl.mono_start) begin
      cnt_next = MONO_LOAD;
    end else if (cnt_reg != MONO_ZERO) begin
      cnt_next = cnt_reg - 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_reg <= MONO_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign ctl.mono_busy = (cnt_reg != MONO_ZERO);

endmodule

// ===== rtl/ssienc_top.sv
`timescale 1ns/100ps
module ssienc_top
  import ssienc_pkg::*;
#(
  parameter bit GRAY_CODE = 1'b1
)
(
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         link_clk_i,
  input  wire logic                         dir_sel_n_i,
  input  wire logic [ssienc_pkg::POS_BITS-1:0] position_i,
  input  wire logic                         status_bit_i,
  output      logic                         ssi_data_o,
  output      logic                         busy_o,
  output      logic                         ring_o
);
  import ssienc_pkg::*;

  ssienc_ctl_if ctl ();

  ssienc_sync u_sync (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .link_clk_i  (link_clk_i),
    .dir_sel_n_i (dir_sel_n_i),
    .ctl         (ctl.sync)
  );

  ssienc_mono u_mono (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ctl     (ctl.mono)
  );

  // Gray conversion of the position field
  function automatic logic [FIELD_BITS-1:0] to_gray(
    input logic [FIELD_BITS-1:0] b
  );
    to_gray = b ^ (b >> 1);
  endfunction

  // Builds the frame from the live position
  function automatic logic [FRAME_BITS-1:0] build_word(
    input logic [POS_BITS-1:0] pos,
    input logic                dir_n,
    input logic                stat
  );
    logic [POS_BITS-1:0]   p;
    logic [FIELD_BITS-1:0] f;
    p = dir_n ? ~pos : pos;
    f = {p[FRM_MT_LSB +: FRM_MT], p[FRM_ST_LSB +: FRM_ST]};
    if (GRAY_CODE) begin
      f = to_gray(f);
    end
    build_word = {f, stat};
  endfunction

  ssienc_state_t          state_reg;
  ssienc_state_t          state_next;
  logic [FRAME_BITS-1:0]  word_reg;
  logic [FRAME_BITS-1:0]  word_next;
  logic [FRAME_BITS-1:0]  shift_reg;
  logic [FRAME_BITS-1:0]  shift_next;
  logic [CNT_W-1:0]       cnt_reg;
  logic [CNT_W-1:0]       cnt_next;
  logic                   ring_reg;
  logic                   ring_next;
  logic                   data_reg;
  logic                   data_next;
  logic                   link_q_reg;
  logic                   fall;
  logic                   rise;
  logic                   capture;
  logic [CNT_W-1:0]       limit;
  logic [FRAME_BITS-1:0]  live_word;

  // Edges of the sampled link clock
  assign fall = link_q_reg & ~ctl.link_clk_s;
  assign rise = ~link_q_reg & ctl.link_clk_s;

  assign live_word = build_word(position_i, ctl.dir_sel_n_s, status_bit_i);
  assign limit     = ring_reg ? RING_CNT : FRAME_CNT;

  always_comb begin
    state_next     = state_reg;
    word_next      = word_reg;
    shift_next     = shift_reg;
    cnt_next       = cnt_reg;
    ring_next      = ring_reg;
    data_next      = data_reg;
    capture        = 1'b0;
    ctl.mono_start = 1'b0;
    case (state_reg)
      SSIENC_IDLE: begin
        data_next = LINE_IDLE;
        capture   = fall;
      end
      SSIENC_SHIFT: begin
        if (rise) begin
          data_next  = shift_reg[FRAME_BITS-1];
          shift_next = shift_reg << 1;
          cnt_next   = cnt_reg + CNT_ONE;
        end else if (fall) begin
          ctl.mono_start = 1'b1;
          if (cnt_reg == limit) begin
            state_next = SSIENC_TAIL;
            data_next  = LINE_LOW;
          end
        end else if (!ctl.mono_busy) begin
          state_next = SSIENC_IDLE;
          data_next  = LINE_IDLE;
          ring_next  = 1'b0;
        end
      end
      SSIENC_TAIL: begin
        data_next = LINE_LOW;
        if (fall && ctl.mono_busy) begin
          state_next     = SSIENC_SHIFT;
          shift_next     = word_reg;
          cnt_next       = CNT_ZERO;
          ring_next      = 1'b1;
          ctl.mono_start = 1'b1;
        end else if (fall) begin
          capture = 1'b1;
        end else if (!ctl.mono_busy) begin
          state_next = SSIENC_IDLE;
          data_next  = LINE_IDLE;
          ring_next  = 1'b0;
        end
      end
      default: begin
        state_next = SSIENC_IDLE;
        data_next  = LINE_IDLE;
        ring_next  = 1'b0;
      end
    endcase
    if (capture) begin
      state_next     = SSIENC_SHIFT;
      word_next      = live_word;
      shift_next     = live_word;
      cnt_next       = CNT_ZERO;
      ring_next      = 1'b0;
      data_next      = LINE_IDLE;
      ctl.mono_start = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg  <= SSIENC_IDLE;
      word_reg   <= '0;
      shift_reg  <= '0;
      cnt_reg    <= CNT_ZERO;
      ring_reg   <= 1'b0;
      data_reg   <= LINE_IDLE;
      link_q_reg <= LINE_IDLE;
    end else begin
      state_reg  <= state_next;
      word_reg   <= word_next;
      shift_reg  <= shift_next;
      cnt_reg    <= cnt_next;
      ring_reg   <= ring_next;
      data_reg   <= data_next;
      link_q_reg <= ctl.link_clk_s;
    end
  end

  assign ssi_data_o = data_reg;
  assign busy_o     = (state_reg != SSIENC_IDLE);
  assign ring_o     = ring_reg;

endmodule

// ===== sim/ssienc_checker.sv
`timescale 1ns/100ps
module ssienc_checker
  import ssienc_pkg::*;
(
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            link_clk_i,
  input  wire logic                            dir_sel_n_i,
  input  wire logic [ssienc_pkg::POS_BITS-1:0] position_i,
  input  wire logic                            status_bit_i,
  input  wire logic                            ssi_data_o,
  input  wire logic                            busy_o,
  input  wire logic                            ring_o
);
  import ssienc_pkg::*;

  logic        link_reg;
  logic        link_next;
  logic [11:0] quiet_reg;
  logic [11:0] quiet_next;

  // Cycles since the link pin last changed
  always_comb begin
    link_next  = link_clk_i;
    quiet_next = quiet_reg;
    if (reset_i) begin
      link_next  = 1'b1;
      quiet_next = 12'h000;
    end else if (link_clk_i != link_reg) begin
      quiet_next = 12'h000;
    end else if (quiet_reg != 12'hFFF) begin
      quiet_next = quiet_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    link_reg  <= link_next;
    quiet_reg <= quiet_next;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_IDLE_HIGH: assert property (!busy_o |-> ssi_data_o && !ring_o)
    else $error("data not high while idle");
  AST_RESET_VAL: assert property ($fell(reset_i) |-> ssi_data_o && !busy_o)
    else $error("bad output values after reset");
  AST_CAPTURE: assert property ($fell(link_clk_i) && !busy_o |-> ##[2:6] busy_o)
    else $error("falling link edge did not start a frame");
  AST_CAPTURE_DATA: assert property ($rose(busy_o) |-> ssi_data_o && !ring_o)
    else $error("data left high level at capture");
  AST_DATA_STABLE: assert property (quiet_reg >= 12'h006 && quiet_reg < 12'h76C
    |=> $stable(ssi_data_o)) else $error("data moved without a link edge");
  AST_TIMEOUT: assert property (quiet_reg == 12'h834 |-> ssi_data_o && !busy_o)
    else $error("monoflop did not expire");
  AST_BUSY_END: assert property ($fell(busy_o) |-> quiet_reg > 12'h76C)
    else $error("frame ended before monoflop time");
  AST_RING_BUSY: assert property (ring_o |-> busy_o)
    else $error("repetition flagged outside a frame");

  COV_FRAME: cover property ($rose(busy_o));
  COV_RING: cover property ($rose(ring_o));
  COV_END: cover property ($fell(busy_o));
endmodule

bind ssienc_top ssienc_checker i_ssienc_checker (
  .clk_i(clk_i), .reset_i(reset_i), .link_clk_i(link_clk_i),
  .dir_sel_n_i(dir_sel_n_i), .position_i(position_i),
  .status_bit_i(status_bit_i), .ssi_data_o(ssi_data_o),
  .busy_o(busy_o), .ring_o(ring_o)
);

// ===== sim/ssienc_master.sv
`timescale 1ns/100ps
module ssienc_master (
  output logic      link_clk_o,
  input  wire logic data_i,
  input  wire logic data_b_i
);
  // Link clock rests high outside bursts
  initial link_clk_o = 1'b1;

  // Burst without gaps, bits sampled before each falling edge
  // First delay keeps every link edge off the system clock edges
  task automatic burst(input int n, output logic [63:0] bits,
                       output logic [63:0] bits_b);
    bits = 64'h0;
    bits_b = 64'h0;
    #61 link_clk_o = 1'b0;
    for (int k = 0; k < n; k++) begin
      #62.5 link_clk_o = 1'b1;
      #62.5 bits = {bits[62:0], data_i};
      bits_b = {bits_b[62:0], data_b_i};
      link_clk_o = 1'b0;
    end
    #62.5 link_clk_o = 1'b1;
  endtask
endmodule

// ===== sim/ssienc_top_test.sv
`timescale 1ns/100ps
module ssienc_top_test;
  import ssienc_pkg::*;
  logic                clk;
  logic                reset;
  logic                link_clk;
  logic                dir_sel_n;
  logic [POS_BITS-1:0] position;
  logic                status_bit;
  logic                ssi_data;
  logic                busy;
  logic                ring;
  logic                ssi_data_b;
  logic [63:0]         got;
  logic [63:0]         got_b;
  int                  err_total;
  int                  tests_run;

  ssienc_top #(.GRAY_CODE(1'b1)) i_ssienc_top (
    .clk_i(clk),
    .reset_i(reset),
    .link_clk_i(link_clk),
    .dir_sel_n_i(dir_sel_n),
    .position_i(position),
    .status_bit_i(status_bit),
    .ssi_data_o(ssi_data),
    .busy_o(busy),
    .ring_o(ring)
  );
  // Plain binary variant on the same link clock
  ssienc_top #(.GRAY_CODE(1'b0)) i_ssienc_top_bin (
    .clk_i(clk),
    .reset_i(reset),
    .link_clk_i(link_clk),
    .dir_sel_n_i(dir_sel_n),
    .position_i(position),
    .status_bit_i(status_bit),
    .ssi_data_o(ssi_data_b),
    .busy_o(),
    .ring_o()
  );
  ssienc_master i_ssienc_master (
    .link_clk_o(link_clk),
    .data_i(ssi_data),
    .data_b_i(ssi_data_b)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [FRAME_BITS-1:0] word(
    input logic [POS_BITS-1:0] pos, input logic dn, input logic st,
    input logic g);
    logic [POS_BITS-1:0]   p;
    logic [FIELD_BITS-1:0] f;
    p = dn ? ~pos : pos;
    f = {p[FRM_MT_LSB+FRM_MT-1:FRM_MT_LSB], p[ST_BITS-1:FRM_ST_LSB]};
    return g ? {f ^ (f >> 1), st} : {f, st};
  endfunction

  // Tail low, then high after the monoflop; next burst only after that
  task automatic tail;
    int n;
    n = 0;
    @(negedge clk);
    check(64'(ssi_data), 64'h0);
    while (ssi_data !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(64'(n >= MONO_CYC - 40 && n <= MONO_CYC + 10), 64'h1);
    check(64'(busy), 64'h0);
    check(64'(ring), 64'h0);
    if (n >= 3000) conclude();
  endtask

  task automatic t_frame(input logic dn, input logic [POS_BITS-1:0] pos,
                         input logic st);
    @(negedge clk);
    dir_sel_n = dn;
    position = pos;
    status_bit = st;
    repeat (5) @(negedge clk);
    fork
      i_ssienc_master.burst(FRAME_BITS, got, got_b);
      begin
        repeat (30) @(negedge clk);
        position = ~pos;
        status_bit = ~st;
      end
    join
    check(64'(got[24:0]), 64'(word(pos, dn, st, 1'b1)));
    check(64'(got[63:25]), 64'h0);
    check(64'(got_b[24:0]), 64'(word(pos, dn, st, 1'b0)));
    tail();
    $display("Frame test done");
  endtask

  task automatic t_ring;
    logic [FRAME_BITS-1:0] w;
    logic                  seen;
    w = word(position, dir_sel_n, status_bit, 1'b1);
    seen = 1'b0;
    fork
      i_ssienc_master.burst(FRAME_BITS + 14, got, got_b);
      begin
        repeat (30) @(negedge clk);
        position = position + 30'h0001234;
        repeat (440) begin
          @(negedge clk);
          seen = seen | ring;
        end
      end
    join
    check(64'(got[38:14]), 64'(w));
    check(64'(got[13]), 64'h0);
    check(64'(got[12:0]), 64'(w[24:12]));
    check(64'(seen), 64'h1);
    tail();
    $display("Ring test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    reset = 1'b1;
    dir_sel_n = 1'b1;
    position = 30'h0000000;
    status_bit = 1'b0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check(64'({ssi_data, busy, ring}), 64'h4);
    repeat (10) @(negedge clk);
    t_frame(1'b1, 30'h2ABC1234, 1'b1);
    t_frame(1'b0, 30'h15A3F0C8, 1'b0);
    t_ring();
    t_frame(1'b1, 30'h3FFFFFFF, 1'b1);
    check(got, 64'h0000000000000001);
    check(got_b, 64'h0000000000000001);
    conclude();
  end
endmodule
